/* File: common/jtgch_consts.svh */
// Constants for the test port instruction and data chains.
`ifndef JTGCH_CONSTS_SVH
`define JTGCH_CONSTS_SVH
`define JTGCH_IR_W       4
`define JTGCH_ID_W       32
`define JTGCH_DBG_W      35
`define JTGCH_ACK_W      3
`define JTGCH_NPAD       8
`define JTGCH_CELLS      3
`define JTGCH_BS_W       (`JTGCH_NPAD * `JTGCH_CELLS)
`define JTGCH_CELL_IN    0
`define JTGCH_CELL_OUT   1
`define JTGCH_CELL_OE    2
`define JTGCH_OP_EXTEST  4'h0
`define JTGCH_OP_INTEST  4'h1
`define JTGCH_OP_SAMPLE  4'h2
`define JTGCH_OP_ABORT   4'h8
`define JTGCH_OP_DBGPORT 4'hA
`define JTGCH_OP_ACCPORT 4'hB
`define JTGCH_OP_IDCODE  4'hE
`define JTGCH_OP_BYPASS  4'hF
`define JTGCH_IR_CAPTURE 4'h1
`define JTGCH_BYP_CAP    1'h0
`define JTGCH_ID_LSB     1'h1
`endif

/* File: common/jtgch_pkg.sv */
// Types shared by the test port chain logic.
`include "jtgch_consts.svh"
package jtgch_pkg;
  typedef enum logic [2:0] {
    JTGCH_SEL_BSC,
    JTGCH_SEL_ABORT,
    JTGCH_SEL_DBGPORT,
    JTGCH_SEL_ACCPORT,
    JTGCH_SEL_IDCODE,
    JTGCH_SEL_BYPASS
  } jtgch_sel_t;

  typedef enum logic [1:0] {
    JTGCH_CH_ABORT,
    JTGCH_CH_DEBUG_PORT,
    JTGCH_CH_ACCESS_PORT
  } jtgch_dchain_t;

  typedef struct packed {
    logic [`JTGCH_IR_W-1:0]    ir_sr;
    logic [`JTGCH_IR_W-1:0]    ir;
    logic [`JTGCH_BS_W-1:0]    bs_sr;
    logic [`JTGCH_BS_W-1:0]    bs_upd;
    logic                      bs_tgl;
    logic [`JTGCH_ID_W-1:0]    id_sr;
    logic                      byp_sr;
    logic [`JTGCH_DBG_W-1:0]   dbg_sr;
    logic [`JTGCH_DBG_W-1:0]   req_data;
    jtgch_dchain_t             req_chain;
    logic                      req_tgl;
    logic [2:0]                rsp_tgl_s;
    logic [`JTGCH_DBG_W-1:0]   rsp_word;
    logic [`JTGCH_BS_W-1:0]    smp_s1;
    logic [`JTGCH_BS_W-1:0]    smp_s2;
    logic                      extest;
    logic                      intest;
    logic                      tdo;
    logic                      tdo_oe_b;
  } jtgch_tck_st_t;

  typedef struct packed {
    logic [1:0]                ext_s;
    logic [1:0]                int_s;
    logic [2:0]                bs_tgl_s;
    logic [`JTGCH_BS_W-1:0]    bs_hold;
    logic [2:0]                req_tgl_s;
    logic                      req_valid;
    logic [`JTGCH_DBG_W-1:0]   req_data;
    jtgch_dchain_t             req_chain;
    logic [`JTGCH_DBG_W-1:0]   rsp_hold;
    logic                      rsp_tgl;
    logic [`JTGCH_NPAD-1:0]    pin_s1;
    logic [`JTGCH_NPAD-1:0]    pin_s2;
    logic [`JTGCH_NPAD-1:0]    pad_out;
    logic [`JTGCH_NPAD-1:0]    pad_oe_b;
    logic [`JTGCH_NPAD-1:0]    core_in;
  } jtgch_clk_st_t;
endpackage

/* File: verilog/jtgch_top.sv */
// Test port instruction register, data chains, boundary cells and debug chain crossing.
module jtgch_top
  import jtgch_pkg::*;
#(
  // Value is arbitrary; replace with the real product code.
  parameter logic [`JTGCH_ID_W-1:0] ID_CODE = 32'h1357_9BDF
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_tck,
  input  wire logic                     i_tck_rst_b,
  input  wire logic                     i_tdi,
  input  wire logic                     i_tlr,
  input  wire logic                     i_capture_ir,
  input  wire logic                     i_shift_ir,
  input  wire logic                     i_update_ir,
  input  wire logic                     i_capture_dr,
  input  wire logic                     i_shift_dr,
  input  wire logic                     i_update_dr,
  output logic                          o_tdo,
  output logic                          o_tdo_oe_b,
  input  wire logic [`JTGCH_NPAD-1:0]   i_pad_in,
  input  wire logic [`JTGCH_NPAD-1:0]   i_core_out,
  input  wire logic [`JTGCH_NPAD-1:0]   i_core_oe,
  output logic      [`JTGCH_NPAD-1:0]   o_pad_out,
  output logic      [`JTGCH_NPAD-1:0]   o_pad_oe_b,
  output logic      [`JTGCH_NPAD-1:0]   o_core_in,
  output logic                          o_dap_req_valid,
  output logic      [`JTGCH_DBG_W-1:0]  o_dap_req_data,
  output jtgch_dchain_t                 o_dap_req_chain,
  input  wire logic                     i_dap_rsp_valid,
  input  wire logic [`JTGCH_DBG_W-1:0]  i_dap_rsp_data
);

  // Unlisted opcodes fall through to bypass so TDI always reaches TDO.
  function automatic jtgch_sel_t jtgch_decode(input logic [`JTGCH_IR_W-1:0] op);
    jtgch_sel_t s;
    case (op)
      `JTGCH_OP_EXTEST:  s = JTGCH_SEL_BSC;
      `JTGCH_OP_INTEST:  s = JTGCH_SEL_BSC;
      `JTGCH_OP_SAMPLE:  s = JTGCH_SEL_BSC;
      `JTGCH_OP_ABORT:   s = JTGCH_SEL_ABORT;
      `JTGCH_OP_DBGPORT: s = JTGCH_SEL_DBGPORT;
      `JTGCH_OP_ACCPORT: s = JTGCH_SEL_ACCPORT;
      `JTGCH_OP_IDCODE:  s = JTGCH_SEL_IDCODE;
      `JTGCH_OP_BYPASS:  s = JTGCH_SEL_BYPASS;
      default:           s = JTGCH_SEL_BYPASS;
    endcase
    return s;
  endfunction

  function automatic jtgch_dchain_t jtgch_chain_of(input jtgch_sel_t s);
    jtgch_dchain_t c;
    case (s)
      JTGCH_SEL_ABORT:   c = JTGCH_CH_ABORT;
      JTGCH_SEL_ACCPORT: c = JTGCH_CH_ACCESS_PORT;
      default:           c = JTGCH_CH_DEBUG_PORT;
    endcase
    return c;
  endfunction

  jtgch_tck_st_t t_r;
  jtgch_tck_st_t t_nxt;
  jtgch_clk_st_t c_r;
  jtgch_clk_st_t c_nxt;

  logic [`JTGCH_BS_W-1:0]  bs_cap;
  logic [`JTGCH_NPAD-1:0]  hold_in;
  logic [`JTGCH_NPAD-1:0]  hold_out;
  logic [`JTGCH_NPAD-1:0]  hold_oe;
  logic [`JTGCH_NPAD-1:0]  smp_in;
  logic [`JTGCH_NPAD-1:0]  smp_out;
  logic [`JTGCH_NPAD-1:0]  smp_oe;

  // The sampled word is packed as enable, output, input groups of all eight pins each.
  assign smp_in  = t_r.smp_s2[`JTGCH_NPAD-1:0];
  assign smp_out = t_r.smp_s2[2*`JTGCH_NPAD-1:`JTGCH_NPAD];
  assign smp_oe  = t_r.smp_s2[3*`JTGCH_NPAD-1:2*`JTGCH_NPAD];

  genvar k;
  generate
    for (k = 0; k < `JTGCH_NPAD; k++) begin : g_cell
      // Pin 0 sits next to the port pins, so its input cell leaves on TDO first.
      assign bs_cap[`JTGCH_CELLS*k+`JTGCH_CELL_IN]  = smp_in[k];
      assign bs_cap[`JTGCH_CELLS*k+`JTGCH_CELL_OUT] = smp_out[k];
      assign bs_cap[`JTGCH_CELLS*k+`JTGCH_CELL_OE]  = smp_oe[k];
      assign hold_in[k]  = c_r.bs_hold[`JTGCH_CELLS*k+`JTGCH_CELL_IN];
      assign hold_out[k] = c_r.bs_hold[`JTGCH_CELLS*k+`JTGCH_CELL_OUT];
      assign hold_oe[k]  = c_r.bs_hold[`JTGCH_CELLS*k+`JTGCH_CELL_OE];
    end
  endgenerate

  // Link side, clocked by TCK. Serial shifting, capture loads and the sampling stages all reach these registers.
  always_comb begin
    jtgch_sel_t sel;
    sel = jtgch_decode(t_r.ir);
    t_nxt = t_r;

    // Pads and core signals belong to other domains and are sampled through two stages.
    t_nxt.smp_s1 = {i_core_oe, i_core_out, i_pad_in};
    t_nxt.smp_s2 = t_r.smp_s1;
    t_nxt.rsp_tgl_s = {t_r.rsp_tgl_s[1:0], c_r.rsp_tgl};
    if (t_r.rsp_tgl_s[2] != t_r.rsp_tgl_s[1]) begin
      t_nxt.rsp_word = c_r.rsp_hold;
    end

    if (i_capture_ir) begin
      t_nxt.ir_sr = `JTGCH_IR_CAPTURE;
    end else if (i_shift_ir) begin
      t_nxt.ir_sr = {i_tdi, t_r.ir_sr[`JTGCH_IR_W-1:1]};
    end
    if (i_tlr) begin
      t_nxt.ir = `JTGCH_OP_IDCODE;
    end else if (i_update_ir) begin
      t_nxt.ir = t_r.ir_sr;
    end

    if (i_capture_dr) begin
      case (sel)
        // Capture happens in all three boundary modes, not only sample.
        JTGCH_SEL_BSC:    t_nxt.bs_sr = bs_cap;
        JTGCH_SEL_IDCODE: t_nxt.id_sr = {ID_CODE[`JTGCH_ID_W-1:1], `JTGCH_ID_LSB};
        JTGCH_SEL_BYPASS: t_nxt.byp_sr = `JTGCH_BYP_CAP;
        // Result and acknowledge come back as one opaque word.
        default:          t_nxt.dbg_sr = t_r.rsp_word;
      endcase
    end else if (i_shift_dr) begin
      case (sel)
        JTGCH_SEL_BSC:    t_nxt.bs_sr = {i_tdi, t_r.bs_sr[`JTGCH_BS_W-1:1]};
        JTGCH_SEL_IDCODE: t_nxt.id_sr = {i_tdi, t_r.id_sr[`JTGCH_ID_W-1:1]};
        JTGCH_SEL_BYPASS: t_nxt.byp_sr = i_tdi;
        default:          t_nxt.dbg_sr = {i_tdi, t_r.dbg_sr[`JTGCH_DBG_W-1:1]};
      endcase
    end else if (i_update_dr) begin
      case (sel)
        JTGCH_SEL_BSC: begin
          t_nxt.bs_upd = t_r.bs_sr;
          t_nxt.bs_tgl = ~t_r.bs_tgl;
        end
        JTGCH_SEL_ABORT, JTGCH_SEL_DBGPORT, JTGCH_SEL_ACCPORT: begin
          t_nxt.req_data  = t_r.dbg_sr;
          t_nxt.req_chain = jtgch_chain_of(sel);
          t_nxt.req_tgl   = ~t_r.req_tgl;
        end
        default: begin
          t_nxt.req_tgl = t_r.req_tgl;
        end
      endcase
    end

    if (i_tlr) begin
      t_nxt.extest = 1'b0;
      t_nxt.intest = 1'b0;
    end else begin
      t_nxt.extest = (t_nxt.ir == `JTGCH_OP_EXTEST);
      t_nxt.intest = (t_nxt.ir == `JTGCH_OP_INTEST);
    end

    // TDO shows bit 0 of the path that the next edge will shift.
    if (i_capture_ir || i_shift_ir) begin
      t_nxt.tdo = t_nxt.ir_sr[0];
    end else begin
      case (jtgch_decode(t_nxt.ir))
        JTGCH_SEL_BSC:    t_nxt.tdo = t_nxt.bs_sr[0];
        JTGCH_SEL_IDCODE: t_nxt.tdo = t_nxt.id_sr[0];
        JTGCH_SEL_BYPASS: t_nxt.tdo = t_nxt.byp_sr;
        default:          t_nxt.tdo = t_nxt.dbg_sr[0];
      endcase
    end
    // The enable has no look-ahead of the TAP state, so it opens at capture and stays one edge past shift.
    t_nxt.tdo_oe_b = ~(i_capture_ir | i_shift_ir | i_capture_dr | i_shift_dr);
  end

  always_ff @(posedge i_tck) begin
    if (!i_tck_rst_b) begin
      t_r          <= '0;
      t_r.ir       <= `JTGCH_OP_IDCODE;
      t_r.tdo_oe_b <= 1'b1;
    end else begin
      t_r <= t_nxt;
    end
  end

  // System side. The boundary hold and request words are copied only after their toggle has settled through the synchroniser.
  always_comb begin
    c_nxt = c_r;
    c_nxt.ext_s     = {c_r.ext_s[0], t_r.extest};
    c_nxt.int_s     = {c_r.int_s[0], t_r.intest};
    c_nxt.bs_tgl_s  = {c_r.bs_tgl_s[1:0], t_r.bs_tgl};
    c_nxt.req_tgl_s = {c_r.req_tgl_s[1:0], t_r.req_tgl};
    c_nxt.pin_s1    = i_pad_in;
    c_nxt.pin_s2    = c_r.pin_s1;
    c_nxt.req_valid = 1'b0;

    if (c_r.bs_tgl_s[2] != c_r.bs_tgl_s[1]) begin
      c_nxt.bs_hold = t_r.bs_upd;
    end
    if (c_r.req_tgl_s[2] != c_r.req_tgl_s[1]) begin
      c_nxt.req_valid = 1'b1;
      c_nxt.req_data  = t_r.req_data;
      c_nxt.req_chain = t_r.req_chain;
    end
    // A second response within a few TCK periods may be torn; the port is expected to pace itself.
    if (i_dap_rsp_valid) begin
      c_nxt.rsp_hold = i_dap_rsp_data;
      c_nxt.rsp_tgl  = ~c_r.rsp_tgl;
    end

    if (c_r.ext_s[1]) begin
      c_nxt.pad_out  = hold_out;
      c_nxt.pad_oe_b = ~hold_oe;
    end else begin
      c_nxt.pad_out  = i_core_out;
      c_nxt.pad_oe_b = ~i_core_oe;
    end
    if (c_r.int_s[1]) begin
      c_nxt.core_in = hold_in;
    end else begin
      c_nxt.core_in = c_r.pin_s2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      c_r          <= '0;
      c_r.pad_oe_b <= '1;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign o_tdo           = t_r.tdo;
  assign o_tdo_oe_b      = t_r.tdo_oe_b;
  assign o_pad_out       = c_r.pad_out;
  assign o_pad_oe_b      = c_r.pad_oe_b;
  assign o_core_in       = c_r.core_in;
  assign o_dap_req_valid = c_r.req_valid;
  assign o_dap_req_data  = c_r.req_data;
  assign o_dap_req_chain = c_r.req_chain;

endmodule

/* File: verification/jtgch_top_props.sv */
// Checker on the test port chain ports.
`include "jtgch_consts.svh"
module jtgch_top_props
  import jtgch_pkg::*;
#(
  parameter logic [`JTGCH_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_tck,
  input wire logic                    i_tck_rst_b,
  input wire logic                    i_tlr,
  input wire logic                    i_capture_ir,
  input wire logic                    i_shift_ir,
  input wire logic                    i_update_ir,
  input wire logic                    i_capture_dr,
  input wire logic                    i_shift_dr,
  input wire logic                    o_tdo,
  input wire logic                    o_tdo_oe_b,
  input wire logic                    o_dap_req_valid,
  input wire logic [`JTGCH_DBG_W-1:0] o_dap_req_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic id_cur_r;
  logic id_cur_nxt;
  logic scan_on;
  // Any instruction update clears the flag, so an update to the default opcode only mutes checks.
  always_comb begin
    id_cur_nxt = id_cur_r;
    if (i_update_ir) begin
      id_cur_nxt = 1'b0;
    end
    if (i_tlr) begin
      id_cur_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_tck) begin
    if (!i_tck_rst_b) begin
      id_cur_r <= 1'b1;
    end else begin
      id_cur_r <= id_cur_nxt;
    end
  end
  assign scan_on = i_capture_ir | i_shift_ir | i_capture_dr | i_shift_dr;
  sequence s_ir_enter;
    i_capture_ir ##1 i_shift_ir;
  endsequence
  sequence s_id_enter;
    id_cur_r && i_capture_dr ##1 i_shift_dr;
  endsequence
  property p_ir_cap;
    @(posedge i_tck) disable iff (!i_tck_rst_b) s_ir_enter |-> o_tdo;
  endproperty
  property p_ir_bit1;
    @(posedge i_tck) disable iff (!i_tck_rst_b) s_ir_enter ##1 i_shift_ir |-> !o_tdo;
  endproperty
  property p_id_lsb;
    @(posedge i_tck) disable iff (!i_tck_rst_b) s_id_enter |-> o_tdo;
  endproperty
  property p_id_bit1;
    @(posedge i_tck) disable iff (!i_tck_rst_b) s_id_enter ##1 i_shift_dr |-> o_tdo == ID_CODE[1];
  endproperty
  property p_oe_on;
    @(posedge i_tck) disable iff (!i_tck_rst_b) scan_on |=> !o_tdo_oe_b;
  endproperty
  property p_oe_off;
    @(posedge i_tck) disable iff (!i_tck_rst_b) !scan_on |=> o_tdo_oe_b;
  endproperty
  property p_req_pulse;
    @(posedge i_clk) disable iff (!i_rst_b) o_dap_req_valid |=> !o_dap_req_valid [*2];
  endproperty
  property p_req_hold;
    // The payload may only move in the cycle that announces it with the valid pulse.
    @(posedge i_clk) disable iff (!i_rst_b) !o_dap_req_valid |-> $stable(o_dap_req_data);
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("ir capture bit0");
  a_ir_bit1: assert property (p_ir_bit1) else $error("ir capture bit1");
  a_id_lsb: assert property (p_id_lsb) else $error("id lsb");
  a_id_bit1: assert property (p_id_bit1) else $error("id bit1");
  a_oe_on: assert property (p_oe_on) else $error("tdo not driven");
  a_oe_off: assert property (p_oe_off) else $error("tdo driven idle");
  a_req_pulse: assert property (p_req_pulse) else $error("request pulse");
  a_req_hold: assert property (p_req_hold) else $error("payload moved");
endmodule

/* File: verification/jtgch_tester.sv */
// Behavioural link tester; its clock runs only inside frames, while idling and when the bench ticks it directly for a TLR pulse.
`include "jtgch_consts.svh"
module jtgch_tester (
  input wire logic i_tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tck = 1'b0;
  logic tdi = 1'b0;
  logic rst_b = 1'b0;
  logic tlr = 1'b0;
  logic cap_ir = 1'b0;
  logic sh_ir = 1'b0;
  logic up_ir = 1'b0;
  logic cap_dr = 1'b0;
  logic sh_dr = 1'b0;
  logic up_dr = 1'b0;
  task automatic tick();
    #6 tck = 1'b1;
    #6 tck = 1'b0;
  endtask
  // The data line toggles while unused so a stale bit never looks valid.
  task automatic idle(input int n);
    repeat (n) begin
      tdi = ~tdi;
      tick();
    end
  endtask
  task automatic reset();
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
  endtask
  task automatic scan(input logic ir, input int n, input logic [`JTGCH_DBG_W-1:0] din,
                      output logic [`JTGCH_DBG_W-1:0] dout);
    dout = '0;
    {cap_ir, cap_dr} = {ir, !ir};
    tick();
    {cap_ir, cap_dr, sh_ir, sh_dr} = {2'b00, ir, !ir};
    for (int k = 0; k < n; k++) begin
      tdi = din[k];
      dout[k] = i_tdo;
      tick();
    end
    {sh_ir, sh_dr, up_ir, up_dr} = {2'b00, ir, !ir};
    tdi = ~tdi;
    tick();
    {up_ir, up_dr} = 2'b00;
  endtask
endmodule

/* File: verification/jtgch_top_bench.sv */
// Self-checking bench for the test port chains.
`include "jtgch_consts.svh"
module jtgch_top_bench;
  import jtgch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Identity value is arbitrary; its low bit is clear to prove the forced one.
  localparam logic [`JTGCH_ID_W-1:0] ID_CODE = 32'h2468_ACE0;
  localparam logic [`JTGCH_DBG_W-1:0] ID_EXP = {3'h0, ID_CODE[31:1], 1'b1};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] pad_in = 8'h00;
  logic [7:0] core_out = 8'h00;
  logic [7:0] core_oe = 8'h00;
  logic rsp_valid = 1'b0;
  logic [`JTGCH_DBG_W-1:0] rsp_data = '0;
  logic tdo, tdo_oe_b, req_valid;
  logic [7:0] pad_out, pad_oe_b, core_in;
  logic [`JTGCH_DBG_W-1:0] req_data, d;
  jtgch_dchain_t req_chain;
  int miscompares = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  jtgch_tester u_jtgch_tester (.i_tdo(tdo));
  jtgch_top #(.ID_CODE(ID_CODE)) u_jtgch_top (
    .i_clk(clk), .i_rst_b(rst_b), .i_tck(u_jtgch_tester.tck), .i_tck_rst_b(u_jtgch_tester.rst_b),
    .i_tdi(u_jtgch_tester.tdi), .i_tlr(u_jtgch_tester.tlr), .i_capture_ir(u_jtgch_tester.cap_ir),
    .i_shift_ir(u_jtgch_tester.sh_ir), .i_update_ir(u_jtgch_tester.up_ir),
    .i_capture_dr(u_jtgch_tester.cap_dr), .i_shift_dr(u_jtgch_tester.sh_dr),
    .i_update_dr(u_jtgch_tester.up_dr), .o_tdo(tdo), .o_tdo_oe_b(tdo_oe_b), .i_pad_in(pad_in),
    .i_core_out(core_out), .i_core_oe(core_oe), .o_pad_out(pad_out), .o_pad_oe_b(pad_oe_b),
    .o_core_in(core_in), .o_dap_req_valid(req_valid), .o_dap_req_data(req_data),
    .o_dap_req_chain(req_chain), .i_dap_rsp_valid(rsp_valid), .i_dap_rsp_data(rsp_data));
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [`JTGCH_DBG_W-1:0] seen, input logic [`JTGCH_DBG_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] cells(input logic [`JTGCH_BS_W-1:0] v, input int pos);
    for (int k = 0; k < 8; k++) cells[k] = v[3*k+pos];
  endfunction
  function automatic logic [`JTGCH_BS_W-1:0] captured();
    for (int k = 0; k < 8; k++) captured[3*k+:3] = {core_oe[k], core_out[k], pad_in[k]};
  endfunction
  task automatic load_ir(input logic [3:0] op);
    u_jtgch_tester.scan(1'b1, 4, {31'h0, op}, d);
    check(d, 35'h1);
  endtask
  task automatic t_bypass();
    logic [3:0] ops [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD, `JTGCH_OP_BYPASS};
    foreach (ops[i]) begin
      load_ir(ops[i]);
      u_jtgch_tester.scan(1'b0, 2, 35'h1, d);
      check(d, 35'h2);
    end
    u_jtgch_tester.tlr = 1'b1;
    u_jtgch_tester.tick();
    u_jtgch_tester.tlr = 1'b0;
    u_jtgch_tester.scan(1'b0, 32, '0, d);
    check(d, ID_EXP);
  endtask
  task automatic t_boundary(input logic [`JTGCH_BS_W-1:0] p);
    @(negedge clk);
    {pad_in, core_out, core_oe} = 24'hA5_3C0F;
    repeat (6) @(negedge clk);
    load_ir(`JTGCH_OP_SAMPLE);
    u_jtgch_tester.scan(1'b0, 24, {11'h0, p}, d);
    check(d, {11'h0, captured()});
    load_ir(`JTGCH_OP_EXTEST);
    repeat (10) @(negedge clk);
    check({27'h0, pad_out}, {27'h0, cells(p, 1)});
    check({27'h0, pad_oe_b}, {27'h0, ~cells(p, 2)});
    u_jtgch_tester.scan(1'b0, 24, {11'h0, ~p}, d);
    check(d, {11'h0, captured()});
    load_ir(`JTGCH_OP_INTEST);
    repeat (10) @(negedge clk);
    check({27'h0, core_in}, {27'h0, cells(~p, 0)});
    check({27'h0, pad_out}, {27'h0, core_out});
  endtask
  task automatic t_debug(input logic [3:0] op, input jtgch_dchain_t ch, input logic [34:0] w);
    int n;
    n = 0;
    load_ir(op);
    u_jtgch_tester.scan(1'b0, 35, w, d);
    do begin
      @(negedge clk);
      n++;
    end while (req_valid !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      wrap_up();
    end
    check(req_data, w);
    check({33'h0, req_chain}, {33'h0, ch});
    rsp_data = ~w;
    rsp_valid = 1'b1;
    @(negedge clk);
    rsp_valid = 1'b0;
    u_jtgch_tester.idle(6);
    u_jtgch_tester.scan(1'b0, 35, w, d);
    check(d, ~w);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    u_jtgch_tester.reset();
    u_jtgch_tester.scan(1'b0, 32, '0, d);
    check(d, ID_EXP);
    t_bypass();
    t_boundary(24'h96_1EC3);
    t_debug(`JTGCH_OP_ABORT, JTGCH_CH_ABORT, 35'h5_1234_5678);
    t_debug(`JTGCH_OP_DBGPORT, JTGCH_CH_DEBUG_PORT, 35'h2_0F0F_A5A5);
    t_debug(`JTGCH_OP_ACCPORT, JTGCH_CH_ACCESS_PORT, 35'h7_8000_0001);
    wrap_up();
  end
endmodule
bind jtgch_top jtgch_top_props #(.ID_CODE(ID_CODE)) u_jtgch_top_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_tck(i_tck), .i_tck_rst_b(i_tck_rst_b), .i_tlr(i_tlr),
  .i_capture_ir(i_capture_ir), .i_shift_ir(i_shift_ir), .i_update_ir(i_update_ir),
  .i_capture_dr(i_capture_dr), .i_shift_dr(i_shift_dr), .o_tdo(o_tdo), .o_tdo_oe_b(o_tdo_oe_b),
  .o_dap_req_valid(o_dap_req_valid), .o_dap_req_data(o_dap_req_data));
